// [rtl/cpu_status_mem_map.vh]
// Purpose: Offsets, field positions, reset values and memory extents for the status word and data memory
// Assumes: Included by the data memory block and its arithmetic flag unit
// Notes: Definitions only
`ifndef CPU_STATUS_MEM_MAP_VH
`define CPU_STATUS_MEM_MAP_VH
`define FLAG_WORD_ADDR 8'hd0
`define STACK_PTR_ADDR 8'h81
`define ACCUM_ADDR 8'he0
`define FLAG_WORD_RESET 8'h00
`define STACK_PTR_RESET 8'h07
`define ACCUM_RESET 8'h00
`define CARRY_BIT 7
`define HALF_CARRY_BIT 6
`define USER_ZERO_BIT 5
`define BANK_HI_BIT 4
`define BANK_LO_BIT 3
`define EXCEPTION_BIT 2
`define USER_ONE_BIT 1
`define PARITY_BIT 0
`define BIT_AREA_BASE 8'h20
`define BIT_AREA_LAST 8'h2f
`define BIT_ADDR_LAST 8'h7f
`define LOWER_RAM_LAST 8'h7f
`define ONCHIP_EXTENDED_RAM_BYTES 4096
`define FLASH_TOP_LARGE 16'hfbff
`define FLASH_TOP_SMALL 16'h7fff
`define OP_NONE 3'h0
`define OP_SUM 3'h1
`define OP_SUM_CARRY 3'h2
`define OP_DIFF_BORROW 3'h3
`define OP_PRODUCT 3'h4
`define OP_QUOTIENT 3'h5
`define OP_OTHER 3'h6
`endif

// [rtl/arith_flag_unit.v]
// Purpose: Computes carry, half carry and exception flags for one arithmetic operation
// Assumes: Operands and op code are valid when the block samples them
// Notes: Purely combinational; the caller latches the results
`timescale 1ns/1ns
`include "cpu_status_mem_map.vh"
module arith_flag_unit (
  input wire [2:0] op, // Operation code
  input wire [7:0] a, // First operand (accumulator)
  input wire [7:0] b, // Second operand
  input wire carry_in, // Current carry flag
  output reg [7:0] result, // Low result byte
  output reg [7:0] result_hi, // High product byte or remainder
  output reg carry_out, // New carry flag
  output reg half_carry, // New half carry flag
  output reg exception, // New exception flag
  output reg updates_ov // High when this op writes the exception flag
);
  reg [8:0] wide;
  reg [4:0] nib;
  reg [15:0] prod;
  reg cin;
  always @* begin
    cin = (op == `OP_SUM_CARRY || op == `OP_DIFF_BORROW) ? carry_in : 1'b0;
    wide = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    result = a;
    result_hi = 8'h00;
    carry_out = 1'b0;
    half_carry = 1'b0;
    exception = 1'b0;
    updates_ov = 1'b0;
    case (op)
      `OP_SUM, `OP_SUM_CARRY: begin
        wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        result = wide[7:0];
        carry_out = wide[8];
        half_carry = nib[4];
        exception = (a[7] == b[7]) && (wide[7] != a[7]);
        updates_ov = 1'b1;
      end
      `OP_DIFF_BORROW: begin
        wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        result = wide[7:0];
        carry_out = wide[8];
        half_carry = nib[4];
        exception = (a[7] != b[7]) && (wide[7] != a[7]);
        updates_ov = 1'b1;
      end
      `OP_PRODUCT: begin
        prod = a * b;
        result = prod[7:0];
        result_hi = prod[15:8];
        exception = (prod[15:8] != 8'h00);
        updates_ov = 1'b1;
      end
      `OP_QUOTIENT: begin
        if (b == 8'h00) begin
          exception = 1'b1;
        end else begin
          result = a / b;
          result_hi = a % b;
        end
        updates_ov = 1'b1;
      end
      default: begin
        result = a;
      end
    endcase
  end
endmodule // arith_flag_unit

// [rtl/cpu_data_memory.v]
// Purpose: Status word, stack pointer, accumulator and 256-byte internal data RAM with bank, bit and stack access
// Assumes: One access per cycle; requests are synchronous to clk
// Notes: Direct accesses above the lower RAM go to special registers; indirect ones go to upper RAM
`timescale 1ns/1ns
`include "cpu_status_mem_map.vh"
// Functional notes
// - Carry flag set on add carry or subtract borrow, else cleared by arithmetic.
// - Half carry flag set on carry into or borrow from upper nibble.
// - Bits 5 and 1 are plain user flags, each bit-addressable.
// - Bank select bits 4:3 pick register bank at 0x00, 0x08, 0x10 or 0x18.
// - Exception flag set on signed overflow, product above 255, or divide by zero.
// - Those five operations clear the exception flag when no overflow occurs.
// - Bit 0 is read-only accumulator parity, one when odd count of ones.
// - Flag word lives at special address 0xD0, bit-addressable, resets to zero.
// - Flash spans 0x0000 to top address; top byte is the lock byte.
// - Flash reads use code fetch; external move writes may be redirected to flash.
// - Internal RAM has 256 bytes; lower 128 reachable directly and indirectly.
// - Above 0x7F direct goes to special registers, indirect to upper RAM.
// - Locations 0x00 to 0x1F form four banks of eight registers, one active.
// - Indirect addressing uses only index registers a and b of active bank; with acc_via_index low the pointer is taken from acc_addr.
// - Bytes 0x20 to 0x2F form 128 bits, address (byte-0x20)*8 plus position.
// - Bit or byte access is chosen by instruction type, not address.
// - Push writes at pointer plus one, then increments the pointer.
// - Reset loads stack pointer with 0x07 so first push lands at 0x08.
// - Stack may sit anywhere in 256 bytes and grow to 256 deep.
// - Provides 4096 bytes of extended RAM besides the 256 internal bytes.
module cpu_data_memory #(
  parameter ONCHIP_EXTENDED_RAM_DEPTH = `ONCHIP_EXTENDED_RAM_BYTES, // Extended RAM size in bytes
  parameter LARGE_FLASH = 1 // 1 selects the larger flash extent
) (
  input wire clk, // Core clock
  input wire rstn, // Asynchronous reset, active low
  input wire acc_req, // Internal data access request
  input wire acc_write, // 1 write, 0 read
  input wire acc_indirect, // 1 indirect addressing mode
  input wire acc_bit, // 1 bit operand instruction
  input wire acc_via_index, // Indirect pointer comes from an index register
  input wire acc_index_sel, // 0 index_reg_a, 1 index_reg_b
  input wire acc_reg, // Access is to working register of active bank
  input wire [2:0] acc_reg_num, // Working register number
  input wire [7:0] acc_addr, // Direct/indirect address or bit address
  input wire [7:0] acc_wdata, // Write byte; bit 0 for bit writes
  input wire push_req, // Push request
  input wire pop_req, // Pop request
  input wire [7:0] push_data, // Byte to push
  input wire [2:0] arith_op, // Arithmetic operation code
  input wire [7:0] arith_b, // Second operand against the accumulator
  input wire xmove_req, // External move request
  input wire xmove_write, // External move is a write
  input wire xmove_to_flash, // Redirect external move writes to flash
  input wire [15:0] xmove_addr, // External move address
  input wire [7:0] xmove_wdata, // External move write data
  input wire [15:0] code_addr, // Code fetch read address
  output reg [7:0] rdata, // Read data from access, pop or external move
  output reg rvalid, // Read data valid, one cycle
  output reg [7:0] flag_word, // Current processor_flag_word, bit 0 held at zero; parity appears only in read data
  output reg [7:0] stack_ptr, // Current stack_top_pointer
  output reg [7:0] accum, // Current accumulator
  output reg [7:0] arith_hi, // High product byte or remainder
  output reg flash_wr, // Flash write strobe from redirected external move
  output reg [15:0] flash_addr, // Flash write address
  output reg [7:0] flash_wdata, // Flash write data
  output wire code_rd, // Code fetch read strobe to flash
  output wire [15:0] code_rd_addr, // Code fetch address to flash
  output wire code_addr_ok, // Code address within flash
  output wire lock_byte_hit // Code address is the lock byte
);
  localparam [15:0] FLASH_TOP = LARGE_FLASH ? `FLASH_TOP_LARGE : `FLASH_TOP_SMALL;
  localparam XW = $clog2(ONCHIP_EXTENDED_RAM_DEPTH);
  reg [7:0] ram_q [0:255];
  reg [7:0] onchip_extended_ram_q [0:ONCHIP_EXTENDED_RAM_DEPTH-1];
  wire [7:0] res;
  wire [7:0] res_hi;
  wire cy_n, ac_n, ov_n, ov_upd;
  reg [7:0] ea;
  reg [7:0] bit_byte;
  reg [2:0] bit_pos;
  reg is_sfr;
  // Address of working register n in the active bank
  function [7:0] bank_reg;
    input [1:0] bank;
    input [2:0] n;
    begin
      bank_reg = {3'b000, bank, n};
    end
  endfunction
  // Current flag word with live parity
  function [7:0] flags_now;
    input [7:0] f;
    input [7:0] a;
    begin
      flags_now = {f[7:1], ^a};
    end
  endfunction
  arith_flag_unit u_arith (
    .op(arith_op),
    .a(accum),
    .b(arith_b),
    .carry_in(flag_word[`CARRY_BIT]),
    .result(res),
    .result_hi(res_hi),
    .carry_out(cy_n),
    .half_carry(ac_n),
    .exception(ov_n),
    .updates_ov(ov_upd)
  );
  // Effective address and target space
  always @* begin
    ea = acc_addr;
    bit_byte = 8'h00;
    bit_pos = acc_addr[2:0];
    is_sfr = 1'b0;
    if (acc_reg) begin
      ea = bank_reg(flag_word[`BANK_HI_BIT:`BANK_LO_BIT], acc_reg_num);
    end else if (acc_indirect && acc_via_index) begin
      ea = ram_q[bank_reg(flag_word[`BANK_HI_BIT:`BANK_LO_BIT], {2'b00, acc_index_sel})];
    end else if (acc_bit) begin
      if (acc_addr <= `BIT_ADDR_LAST) begin
        ea = `BIT_AREA_BASE + {3'b000, acc_addr[7:3]};
      end else begin
        ea = {acc_addr[7:3], 3'b000}; // Bit-addressable special register
        is_sfr = 1'b1;
      end
    end else if (!acc_indirect && acc_addr > `LOWER_RAM_LAST) begin
      is_sfr = 1'b1;
    end
    if (is_sfr) begin
      if (ea == `FLAG_WORD_ADDR) begin
        bit_byte = flags_now(flag_word, accum);
      end else if (ea == `STACK_PTR_ADDR) begin
        bit_byte = stack_ptr;
      end else if (ea == `ACCUM_ADDR) begin
        bit_byte = accum;
      end else begin
        bit_byte = 8'h00;
      end
    end else begin
      bit_byte = ram_q[ea];
    end
  end
  // Core state
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_word <= `FLAG_WORD_RESET;
      stack_ptr <= `STACK_PTR_RESET;
      accum <= `ACCUM_RESET;
      arith_hi <= 8'h00;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      flash_wr <= 1'b0;
      flash_addr <= 16'h0000;
      flash_wdata <= 8'h00;
    end else begin
      rvalid <= 1'b0;
      flash_wr <= 1'b0;
      if (arith_op != `OP_NONE) begin
        accum <= res;
        arith_hi <= res_hi;
        if (arith_op != `OP_PRODUCT && arith_op != `OP_QUOTIENT) begin
          flag_word[`CARRY_BIT] <= cy_n;
          flag_word[`HALF_CARRY_BIT] <= ac_n;
        end else begin
          flag_word[`CARRY_BIT] <= 1'b0;
        end
        if (ov_upd) begin
          flag_word[`EXCEPTION_BIT] <= ov_n;
        end
      end else if (push_req) begin
        ram_q[stack_ptr + 8'h01] <= push_data;
        stack_ptr <= stack_ptr + 8'h01;
      end else if (pop_req) begin
        rdata <= ram_q[stack_ptr];
        rvalid <= 1'b1;
        stack_ptr <= stack_ptr - 8'h01;
      end else if (xmove_req) begin
        if (xmove_write && xmove_to_flash) begin
          flash_wr <= 1'b1;
          flash_addr <= xmove_addr;
          flash_wdata <= xmove_wdata;
        end else if (xmove_write) begin
          onchip_extended_ram_q[xmove_addr[XW-1:0]] <= xmove_wdata;
        end else begin
          rdata <= onchip_extended_ram_q[xmove_addr[XW-1:0]];
          rvalid <= 1'b1;
        end
      end else if (acc_req) begin
        if (!acc_write) begin
          rdata <= acc_bit ? {7'h00, bit_byte[bit_pos]} : bit_byte;
          rvalid <= 1'b1;
        end else if (is_sfr) begin
          if (ea == `FLAG_WORD_ADDR) begin
            if (acc_bit) begin
              if (bit_pos != `PARITY_BIT) begin
                flag_word[bit_pos] <= acc_wdata[0];
              end
            end else begin
              flag_word <= {acc_wdata[7:1], 1'b0};
            end
          end else if (ea == `STACK_PTR_ADDR && !acc_bit) begin
            stack_ptr <= acc_wdata;
          end else if (ea == `ACCUM_ADDR) begin
            if (acc_bit) begin
              accum[bit_pos] <= acc_wdata[0];
            end else begin
              accum <= acc_wdata;
            end
          end
        end else if (acc_bit) begin
          ram_q[ea][bit_pos] <= acc_wdata[0];
        end else begin
          ram_q[ea] <= acc_wdata;
        end
      end
    end
  end
  assign code_rd = 1'b1;
  assign code_rd_addr = code_addr;
  assign code_addr_ok = (code_addr <= FLASH_TOP);
  assign lock_byte_hit = (code_addr == FLASH_TOP);
endmodule // cpu_data_memory

// [verif/cpu_data_memory_chk.sv]
// Purpose: Port-level checks on stack, arithmetic flags and flash map
// Assumes: Bound to cpu_data_memory; one clock domain
// Notes: Flag bit 0 is checked only by the reset value assertion, which compares the whole flag word
`timescale 1ns/1ns
`include "cpu_status_mem_map.vh"
module cpu_data_memory_chk #(
  parameter LARGE_FLASH = 1
) (
  input wire clk, // Core clock
  input wire rstn, // Reset, active low
  input wire push_req, // Push
  input wire pop_req, // Pop
  input wire [7:0] push_data, // Pushed byte
  input wire [2:0] arith_op, // Operation
  input wire [7:0] arith_b, // Operand
  input wire [7:0] rdata, // Read data
  input wire rvalid, // Read valid
  input wire [7:0] flag_word, // Flag word
  input wire [7:0] stack_ptr, // Stack pointer
  input wire [7:0] accum, // Accumulator
  input wire [15:0] code_addr, // Fetch address
  input wire code_addr_ok, // Address in flash
  input wire lock_byte_hit // Lock byte
);
  wire [8:0] sum9 = accum + arith_b;
  wire [4:0] half5 = accum[3:0] + arith_b[3:0];
  wire [15:0] prod = accum * arith_b;
  wire prod_ov = |prod[15:8];
  wire [15:0] top = LARGE_FLASH ? `FLASH_TOP_LARGE : `FLASH_TOP_SMALL;
  wire no_ar = arith_op == `OP_NONE;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_push;
    push_req && no_ar;
  endsequence
  sequence s_pop;
    pop_req && !push_req && no_ar;
  endsequence
  a_reset_values: assert property ($rose(rstn) |-> stack_ptr == 8'h07 && flag_word == 8'h00)
    else $error("reset values wrong");
  a_push_ptr: assert property (s_push |=> stack_ptr == $past(stack_ptr) + 8'h01)
    else $error("push pointer wrong");
  a_pop_ptr: assert property (s_pop |=> rvalid && stack_ptr == $past(stack_ptr) - 8'h01)
    else $error("pop pointer wrong");
  a_push_pop_data: assert property (s_push ##1 s_pop |=> rdata == $past(push_data, 2))
    else $error("popped byte wrong");
  a_sum_carry: assert property (arith_op == `OP_SUM |=> flag_word[7] == $past(sum9[8]) && accum == $past(sum9[7:0]))
    else $error("sum carry wrong");
  a_sum_half: assert property (arith_op == `OP_SUM |=> flag_word[6] == $past(half5[4]))
    else $error("half carry wrong");
  a_product_ov: assert property (arith_op == `OP_PRODUCT |=> flag_word[2] == $past(prod_ov) && !flag_word[7])
    else $error("product overflow wrong");
  a_div_zero: assert property (arith_op == `OP_QUOTIENT && arith_b == 8'h00 |=> flag_word[2] && !flag_word[7])
    else $error("divide by zero flag wrong");
  a_ov_clear: assert property (arith_op == `OP_SUM && accum[7] != arith_b[7] |=> !flag_word[2])
    else $error("overflow not cleared");
  a_flash_lock: assert property (lock_byte_hit == (code_addr == top) && code_addr_ok == (code_addr <= top))
    else $error("flash map wrong");
endmodule // cpu_data_memory_chk

// [verif/cpu_status_word_and_data_memory_tb.sv]
// Purpose: Self-checking bench for the status word and data memory
// Assumes: Inputs driven at falling edges; reads expected in order
// Notes: Flags and accumulator are modelled here; the flag word is also read back after each arithmetic step except divide by zero
`timescale 1ns/1ns
`include "cpu_status_mem_map.vh"
module cpu_status_word_and_data_memory_tb;
  logic clk = 0, rstn = 0, acc_req = 0, acc_write = 0, acc_indirect = 0, acc_bit = 0, acc_via_index = 0;
  logic acc_index_sel = 0, acc_reg = 0, push_req = 0, pop_req = 0, xmove_req = 0, xmove_write = 0, xmove_to_flash = 0;
  logic [2:0] acc_reg_num = 0, arith_op = 0;
  logic [7:0] acc_addr = 0, acc_wdata = 0, push_data = 0, arith_b = 0, xmove_wdata = 0, d, fw_m = 0;
  logic [15:0] xmove_addr = 0, code_addr = 0;
  wire [7:0] rdata, flag_word, stack_ptr, accum, arith_hi, flash_wdata;
  wire [15:0] flash_addr, code_rd_addr;
  wire rvalid, flash_wr, code_rd, code_addr_ok, lock_byte_hit;
  logic [7:0] exp_q[$];
  int err_total = 0, checks = 0, cyc = 0, i;
  cpu_data_memory #(.ONCHIP_EXTENDED_RAM_DEPTH(4096), .LARGE_FLASH(1)) cpu_data_memory_i (.clk(clk), .rstn(rstn),
    .acc_req(acc_req), .acc_write(acc_write), .acc_indirect(acc_indirect), .acc_bit(acc_bit),
    .acc_via_index(acc_via_index), .acc_index_sel(acc_index_sel), .acc_reg(acc_reg), .acc_reg_num(acc_reg_num),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .push_req(push_req), .pop_req(pop_req), .push_data(push_data),
    .arith_op(arith_op), .arith_b(arith_b), .xmove_req(xmove_req), .xmove_write(xmove_write),
    .xmove_to_flash(xmove_to_flash), .xmove_addr(xmove_addr), .xmove_wdata(xmove_wdata), .code_addr(code_addr),
    .rdata(rdata), .rvalid(rvalid), .flag_word(flag_word), .stack_ptr(stack_ptr), .accum(accum),
    .arith_hi(arith_hi), .flash_wr(flash_wr), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .code_rd(code_rd), .code_rd_addr(code_rd_addr), .code_addr_ok(code_addr_ok), .lock_byte_hit(lock_byte_hit));
  always #5 clk = ~clk;
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Mode bits: indirect, bit operand, working register, pointer from index register
  task automatic acc(input logic w, input logic [3:0] m, input logic [7:0] a, input logic [7:0] v);
    {acc_indirect, acc_bit, acc_reg, acc_via_index} = m;
    acc_req = 1; acc_write = w; acc_addr = a; acc_reg_num = a[2:0]; acc_index_sel = a[0]; acc_wdata = v;
    @(negedge clk);
    acc_req = 0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [3:0] m, input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(0, m, a, 8'h00);
  endtask
  task automatic wflag(input logic [7:0] v);
    acc(1, 4'h0, `FLAG_WORD_ADDR, v);
    fw_m = v & 8'hfe;
    chk8({flag_word[7:1], 1'b0}, fw_m, "flag word write");
  endtask
  task automatic xm(input logic w, input logic f, input logic [15:0] a, input logic [7:0] v);
    xmove_req = 1; xmove_write = w; xmove_to_flash = f; xmove_addr = a; xmove_wdata = v;
    @(negedge clk);
    xmove_req = 0;
    chk8({7'h00, flash_wr}, {7'h00, w & f}, "flash write strobe");
    @(negedge clk);
  endtask
  task automatic arith(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic [15:0] p;
    logic cc, ov, dz;
    acc(1, 4'h0, `ACCUM_ADDR, a);
    cc = (op == `OP_SUM) ? 1'b0 : fw_m[7];
    dz = (op == `OP_QUOTIENT) && (b == 8'h00);
    p = a * b;
    arith_op = op; arith_b = b;
    @(negedge clk);
    arith_op = `OP_NONE;
    if (op <= `OP_SUM_CARRY) begin
      s = a + b + cc; h = a[3:0] + b[3:0] + cc; ov = (a[7] == b[7]) && (s[7] != a[7]);
    end else if (op == `OP_DIFF_BORROW) begin
      s = a - b - cc; h = a[3:0] - b[3:0] - cc; ov = (a[7] != b[7]) && (s[7] != a[7]);
    end else begin
      s = (op == `OP_PRODUCT) ? {1'b0, p[7:0]} : (dz ? 9'h000 : {1'b0, a / b});
      h = {fw_m[6], 4'h0};
      ov = (op == `OP_PRODUCT) ? (|p[15:8]) : dz;
      if (!dz) chk8(arith_hi, (op == `OP_PRODUCT) ? p[15:8] : a % b, "high byte");
    end
    fw_m = {s[8], h[4], fw_m[5:3], ov, fw_m[1], 1'b0};
    chk8({flag_word[7:1], 1'b0}, fw_m, "arith flags");
    if (!dz) chk8(accum, s[7:0], "accumulator");
    if (!dz) rd(4'h0, `FLAG_WORD_ADDR, {fw_m[7:1], ^s[7:0]});
  endtask
  always @(posedge clk) begin
    #1;
    if (rvalid === 1'b1) begin
      if (exp_q.size() > 0) chk8(rdata, exp_q.pop_front(), "read data");
      else chk8(rdata, 8'hxx, "unexpected read data");
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(69943));
    repeat (10) @(negedge clk);
    rstn = 1;
    chk8(stack_ptr, `STACK_PTR_RESET, "stack pointer reset");
    chk8(flag_word, `FLAG_WORD_RESET, "flag word reset");
    d = 8'($urandom);
    push_req = 1; push_data = d;
    @(negedge clk);
    push_req = 0; pop_req = 1;
    exp_q.push_back(d);
    @(negedge clk);
    pop_req = 0;
    chk8(stack_ptr, 8'h07, "pointer after pop");
    push_req = 1;
    @(negedge clk);
    push_req = 0;
    chk8(stack_ptr, 8'h08, "pointer after push");
    rd(4'h0, 8'h08, d);
    acc(1, 4'h0, 8'h00, 8'h5a);
    acc(1, 4'h0, `STACK_PTR_ADDR, 8'h00);
    pop_req = 1;
    exp_q.push_back(8'h5a);
    @(negedge clk);
    pop_req = 0;
    chk8(stack_ptr, 8'hff, "pointer wrap");
    for (i = 0; i < 4; i++) begin
      wflag(8'(i << 3) | 8'h23);
      d = 8'($urandom);
      acc(1, 4'h0, 8'(i * 8 + 5), d);
      rd(4'h2, 8'h05, d);
      acc(1, 4'h0, 8'(i * 8 + 1), 8'(8'h40 + i));
      acc(1, 4'h0, 8'(8'h40 + i), ~d);
      rd(4'h9, 8'h01, ~d);
    end
    acc(1, 4'h8, 8'h90, 8'h3c);
    rd(4'h0, 8'h90, 8'h00);
    rd(4'h8, 8'h90, 8'h3c);
    acc(1, 4'h0, 8'h30, 8'hc3);
    rd(4'h8, 8'h30, 8'hc3);
    acc(1, 4'h0, 8'h13, 8'ha5);
    acc(1, 4'h0, 8'h22, 8'h00);
    acc(1, 4'h0, 8'h2f, 8'h00);
    acc(1, 4'h4, 8'h13, 8'h01);
    acc(1, 4'h4, 8'h7f, 8'h01);
    rd(4'h0, 8'h22, 8'h08);
    rd(4'h0, 8'h2f, 8'h80);
    rd(4'h0, 8'h13, 8'ha5);
    wflag(8'h00);
    acc(1, 4'h4, 8'hd5, 8'h01);
    acc(1, 4'h4, 8'hd1, 8'h01);
    fw_m = 8'h22;
    chk8({flag_word[7:1], 1'b0}, fw_m, "user flag bits");
    for (i = 0; i < 15; i++) arith(3'(i % 5 + 1), 8'($urandom), 8'($urandom));
    arith(`OP_SUM, 8'h7f, 8'h01);
    arith(`OP_SUM, 8'h7f, 8'h81);
    arith(`OP_DIFF_BORROW, 8'h00, 8'h01);
    arith(`OP_PRODUCT, 8'h10, 8'h10);
    arith(`OP_QUOTIENT, 8'h37, 8'h00);
    xm(1, 0, 16'h0fff, 8'h6e);
    exp_q.push_back(8'h6e);
    xm(0, 0, 16'h0fff, 8'h00);
    xm(1, 1, 16'h1234, 8'h9d);
    chk8(flash_addr[15:8], 8'h12, "flash write address high");
    chk8(flash_addr[7:0], 8'h34, "flash write address low");
    chk8(flash_wdata, 8'h9d, "flash write data");
    code_addr = 16'hfbff;
    @(negedge clk);
    chk8({7'h00, code_rd}, 8'h01, "code fetch strobe");
    chk8(code_rd_addr[15:8], 8'hfb, "code fetch address high");
    chk8(code_rd_addr[7:0], 8'hff, "code fetch address low");
    chk8({6'h00, lock_byte_hit, code_addr_ok}, 8'h03, "lock byte");
    code_addr = 16'hfc00;
    @(negedge clk);
    chk8({6'h00, lock_byte_hit, code_addr_ok}, 8'h00, "reserved flash");
    chk8(8'(exp_q.size()), 8'h00, "reads outstanding");
    give_verdict();
  end
endmodule // cpu_status_word_and_data_memory_tb
bind cpu_data_memory cpu_data_memory_chk #(.LARGE_FLASH(LARGE_FLASH)) cpu_data_memory_chk_i (.clk(clk), .rstn(rstn),
  .push_req(push_req), .pop_req(pop_req), .push_data(push_data), .arith_op(arith_op), .arith_b(arith_b),
  .rdata(rdata), .rvalid(rvalid), .flag_word(flag_word), .stack_ptr(stack_ptr), .accum(accum),
  .code_addr(code_addr), .code_addr_ok(code_addr_ok), .lock_byte_hit(lock_byte_hit));
